// >>> rtl/cpuseq_bus_unit.sv
// Bus cycle sequencer for a 16-bit demultiplexed local bus with
// pipelined addressing, locked cycles and interrupt acknowledge.
// Assumes external logic answers every cycle with ready_n_in.
`timescale 1ns/1ps
module cpuseq_bus_unit (
	input wire logic clk_sys_in,
	input wire logic rstn_in,
	input wire logic req_valid_in,
	output logic req_ready_out,
	input wire logic [22:0] req_addr_in,
	input wire logic [1:0] req_be_n_in,
	input wire logic req_write_in,
	input wire logic req_data_ctl_in,
	input wire logic req_mem_io_in,
	input wire logic req_lock_in,
	input wire logic [15:0] req_wdata_in,
	output logic rd_valid_out,
	output logic [15:0] rd_data_out,
	input wire logic maskable_interrupt_request_in,
	input wire logic maskable_interrupt_request_enable_in,
	output logic vector_valid_out,
	output logic [7:0] vector_out,
	output logic address_strobe_n_out,
	output logic [22:0] addr_out,
	output logic high_byte_enable_n_out,
	output logic low_byte_enable_n_out,
	output logic write_read_out,
	output logic data_control_out,
	output logic mem_io_out,
	output logic bus_lock_n_out,
	input wire logic [15:0] data_in,
	output logic [15:0] data_out,
	output logic data_oe_out,
	input wire logic ready_n_in,
	input wire logic next_address_request_n_in
);
	cpuseq_pkg::cpuseq_bus_state_type state_ff; // Current bus state
	cpuseq_pkg::cpuseq_bus_state_type nxt_state; // State at the state end
	cpuseq_pkg::cpuseq_interrupt_acknowledge_cycle_state_type interrupt_acknowledge_cycle_ff; // Acknowledge sequence
	logic phase_ff; // Phase within the bus state
	logic na_seen_ff; // Next-address request seen in this cycle
	logic [2:0] gap_cnt_ff; // Idle states counted between acknowledges
	logic [cpuseq_pkg::REQ_W-1:0] buf_data; // Head of request buffer
	logic buf_valid; // Buffer holds a request
	// Fields of the request about to be issued
	logic [22:0] src_addr;
	logic [1:0] src_be_n;
	logic src_wr, src_dc, src_mio, src_lock, src_interrupt_acknowledge_cycle, src_inta2;
	logic [15:0] src_wdata;
	// Issued but not yet started cycle (pipelined address)
	logic pnd_wr_ff, pnd_lock_ff, pnd_interrupt_acknowledge_cycle_ff, pnd_inta2_ff;
	logic [15:0] pnd_wdata_ff;
	// Cycle now in progress
	logic cur_wr_ff, cur_interrupt_acknowledge_cycle_ff, cur_inta2_ff;
	logic [15:0] cur_wdata_ff;
	logic state_end; // Last clock of a bus state
	logic in_second; // Any second-type state
	logic ack; // Cycle acknowledged this clock
	logic pending; // Internal request waiting
	logic interrupt_acknowledge_cycle_src; // Acknowledge sequence owns the next issue
	logic issue; // Next address placed on the bus
	logic pop; // Request buffer head consumed

	// Request buffer between core and sequencer
	cpuseq_buf2 #(
		.WIDTH(cpuseq_pkg::REQ_W)
	) u_req_buf (
		.clk_sys_in(clk_sys_in),
		.rstn_in(rstn_in),
		.in_valid_in(req_valid_in),
		.in_ready_out(req_ready_out),
		.in_data_in({req_lock_in, req_mem_io_in, req_data_ctl_in,
			req_write_in, req_be_n_in, req_addr_in, req_wdata_in}),
		.out_valid_out(buf_valid),
		.out_ready_in(pop),
		.out_data_out(buf_data)
	);

	assign state_end = (phase_ff == cpuseq_pkg::PHASE_TWO);
	assign in_second = (state_ff == cpuseq_pkg::st_second) ||
		(state_ff == cpuseq_pkg::st_pipe_next) ||
		(state_ff == cpuseq_pkg::st_pipe_no_next);
	// Ready counts only at the end of second-type states
	assign ack = state_end & in_second & ~ready_n_in;
	// Acknowledge source: first request, or the fourth idle state end
	assign interrupt_acknowledge_cycle_src = (interrupt_acknowledge_cycle_ff == cpuseq_pkg::ia_req1) ||
		((interrupt_acknowledge_cycle_ff == cpuseq_pkg::ia_gap) &&
		(gap_cnt_ff == cpuseq_pkg::INTERRUPT_ACKNOWLEDGE_CYCLE_GAP_LAST) &&
		(state_ff == cpuseq_pkg::st_idle));
	// Buffer is held off for the whole acknowledge sequence
	assign pending = interrupt_acknowledge_cycle_src ||
		((interrupt_acknowledge_cycle_ff == cpuseq_pkg::ia_off) && buf_valid);
	assign issue = state_end && ((nxt_state == cpuseq_pkg::st_first) ||
		((nxt_state == cpuseq_pkg::st_pipe_next) &&
		(state_ff != cpuseq_pkg::st_pipe_next)));
	assign pop = issue & ~interrupt_acknowledge_cycle_src;

	// Select the fields of the next request
	always_comb begin
		src_interrupt_acknowledge_cycle = interrupt_acknowledge_cycle_src;
		src_inta2 = (interrupt_acknowledge_cycle_ff == cpuseq_pkg::ia_gap);
		if (interrupt_acknowledge_cycle_src) begin
			src_addr = src_inta2 ? cpuseq_pkg::INTA2_ADDR :
				cpuseq_pkg::INTA1_ADDR;
			src_be_n = cpuseq_pkg::INTERRUPT_ACKNOWLEDGE_CYCLE_BE_N;
			src_wr = 1'b0;
			src_dc = 1'b0;
			src_mio = 1'b0;
			src_lock = 1'b1;
			src_wdata = cpuseq_pkg::DATA_RST;
		end else begin
			src_addr = buf_data[cpuseq_pkg::REQ_ADDR_LSB +: 23];
			src_be_n = buf_data[cpuseq_pkg::REQ_BE_LSB +: 2];
			src_wr = buf_data[cpuseq_pkg::REQ_WR_BIT];
			src_dc = buf_data[cpuseq_pkg::REQ_DC_BIT];
			src_mio = buf_data[cpuseq_pkg::REQ_MIO_BIT];
			src_lock = buf_data[cpuseq_pkg::REQ_LOCK_BIT];
			src_wdata = buf_data[cpuseq_pkg::REQ_WDATA_LSB +: 16];
		end
	end

	// State that follows at the end of the current state
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			cpuseq_pkg::st_idle: begin
				// Always a plain cycle out of idle
				if (pending) begin
					nxt_state = cpuseq_pkg::st_first;
				end
			end
			cpuseq_pkg::st_first: begin
				nxt_state = cpuseq_pkg::st_second;
			end
			cpuseq_pkg::st_pipe_first: begin
				if (pending && na_seen_ff) begin
					nxt_state = cpuseq_pkg::st_pipe_next;
				end else if (pending) begin
					nxt_state = cpuseq_pkg::st_second;
				end else begin
					nxt_state = cpuseq_pkg::st_pipe_no_next;
				end
			end
			cpuseq_pkg::st_pipe_next: begin
				// Cycle ending here keeps pipelining
				if (ack) begin
					nxt_state = cpuseq_pkg::st_pipe_first;
				end
			end
			default: begin
				// Plain or no-next second state
				if (ack) begin
					nxt_state = pending ? cpuseq_pkg::st_first :
						cpuseq_pkg::st_idle;
				end else if (pending && na_seen_ff) begin
					nxt_state = cpuseq_pkg::st_pipe_next;
				end
			end
		endcase
	end

	// Phase and bus state registers
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			phase_ff <= cpuseq_pkg::PHASE_ONE;
			state_ff <= cpuseq_pkg::st_idle;
		end else begin
			phase_ff <= ~phase_ff;
			if (state_end) begin
				state_ff <= nxt_state;
			end
		end
	end

	// Next-address sampling at each phase-one end once address settled
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			na_seen_ff <= 1'b0;
		end else if (state_end && ((nxt_state == cpuseq_pkg::st_first) ||
			(nxt_state == cpuseq_pkg::st_pipe_first) ||
			(nxt_state == cpuseq_pkg::st_idle))) begin
			na_seen_ff <= 1'b0;
		end else if (!state_end && !next_address_request_n_in &&
			state_ff != cpuseq_pkg::st_first) begin
			na_seen_ff <= 1'b1;
		end
	end

	// Address, byte enables and cycle definition pins
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			addr_out <= cpuseq_pkg::ADDR_RST;
			high_byte_enable_n_out <= 1'b1;
			low_byte_enable_n_out <= 1'b1;
			write_read_out <= 1'b0;
			data_control_out <= 1'b0;
			mem_io_out <= 1'b0;
		end else if (issue) begin
			// Held through every repeated state until the next issue
			addr_out <= src_addr;
			{high_byte_enable_n_out, low_byte_enable_n_out} <= src_be_n;
			write_read_out <= src_wr;
			data_control_out <= src_dc;
			mem_io_out <= src_mio;
		end
	end

	// Address strobe: phase one of a plain first state, whole next-addr
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			address_strobe_n_out <= 1'b1;
		end else if (state_end) begin
			address_strobe_n_out <= ~((nxt_state == cpuseq_pkg::st_first) ||
				(nxt_state == cpuseq_pkg::st_pipe_next));
		end else if (state_ff == cpuseq_pkg::st_first) begin
			address_strobe_n_out <= 1'b1;
		end
	end

	// Issued-but-waiting cycle and cycle in progress
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pnd_wr_ff <= 1'b0;
			pnd_lock_ff <= 1'b0;
			pnd_interrupt_acknowledge_cycle_ff <= 1'b0;
			pnd_inta2_ff <= 1'b0;
			pnd_wdata_ff <= cpuseq_pkg::DATA_RST;
			cur_wr_ff <= 1'b0;
			cur_interrupt_acknowledge_cycle_ff <= 1'b0;
			cur_inta2_ff <= 1'b0;
			cur_wdata_ff <= cpuseq_pkg::DATA_RST;
		end else begin
			if (issue) begin
				pnd_wr_ff <= src_wr;
				pnd_lock_ff <= src_lock;
				pnd_interrupt_acknowledge_cycle_ff <= src_interrupt_acknowledge_cycle;
				pnd_inta2_ff <= src_inta2;
				pnd_wdata_ff <= src_wdata;
			end
			if (issue && nxt_state == cpuseq_pkg::st_first) begin
				cur_wr_ff <= src_wr;
				cur_interrupt_acknowledge_cycle_ff <= src_interrupt_acknowledge_cycle;
				cur_inta2_ff <= src_inta2;
				cur_wdata_ff <= src_wdata;
			end else if (state_end &&
				nxt_state == cpuseq_pkg::st_pipe_first) begin
				cur_wr_ff <= pnd_wr_ff;
				cur_interrupt_acknowledge_cycle_ff <= pnd_interrupt_acknowledge_cycle_ff;
				cur_inta2_ff <= pnd_inta2_ff;
				cur_wdata_ff <= pnd_wdata_ff;
			end
		end
	end

	// Data drive: from phase two of a first state, held through phase one
	// of the state after acknowledge
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			data_oe_out <= 1'b0;
			data_out <= cpuseq_pkg::DATA_RST;
		end else if (!state_end) begin
			if (state_ff == cpuseq_pkg::st_first ||
				state_ff == cpuseq_pkg::st_pipe_first) begin
				data_oe_out <= cur_wr_ff;
				data_out <= cur_wdata_ff;
			end else if (!in_second) begin
				data_oe_out <= 1'b0;
			end
		end
	end

	// Read data and vector capture at acknowledge
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rd_valid_out <= 1'b0;
			rd_data_out <= cpuseq_pkg::DATA_RST;
			vector_valid_out <= 1'b0;
			vector_out <= cpuseq_pkg::VEC_RST;
		end else begin
			rd_valid_out <= ack & ~cur_wr_ff & ~cur_interrupt_acknowledge_cycle_ff;
			vector_valid_out <= ack & cur_inta2_ff;
			if (ack && !cur_wr_ff && !cur_interrupt_acknowledge_cycle_ff) begin
				rd_data_out <= data_in;
			end
			// First acknowledge data is dropped
			if (ack && cur_inta2_ff) begin
				vector_out <= data_in[7:0];
			end
		end
	end

	// Bus lock: set as a locked cycle starts, released at last ack
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			bus_lock_n_out <= 1'b1;
		end else if (issue && nxt_state == cpuseq_pkg::st_first &&
			src_lock) begin
			bus_lock_n_out <= 1'b0;
		end else if (state_end && nxt_state == cpuseq_pkg::st_pipe_first &&
			pnd_lock_ff) begin
			bus_lock_n_out <= 1'b0;
		end else if (ack && !(cur_interrupt_acknowledge_cycle_ff && !cur_inta2_ff)) begin
			bus_lock_n_out <= 1'b1;
		end
	end

	// Interrupt acknowledge sequence
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			interrupt_acknowledge_cycle_ff <= cpuseq_pkg::ia_off;
			gap_cnt_ff <= cpuseq_pkg::GAP_CNT_RST;
		end else begin
			case (interrupt_acknowledge_cycle_ff)
				cpuseq_pkg::ia_off: begin
					if (maskable_interrupt_request_in && maskable_interrupt_request_enable_in) begin
						interrupt_acknowledge_cycle_ff <= cpuseq_pkg::ia_req1;
					end
				end
				cpuseq_pkg::ia_req1: begin
					if (issue) begin
						interrupt_acknowledge_cycle_ff <= cpuseq_pkg::ia_busy1;
					end
				end
				cpuseq_pkg::ia_busy1: begin
					if (ack && cur_interrupt_acknowledge_cycle_ff) begin
						interrupt_acknowledge_cycle_ff <= cpuseq_pkg::ia_gap;
						gap_cnt_ff <= cpuseq_pkg::GAP_CNT_RST;
					end
				end
				cpuseq_pkg::ia_gap: begin
					// Count idle states; fourth one issues second cycle
					if (issue) begin
						interrupt_acknowledge_cycle_ff <= cpuseq_pkg::ia_busy2;
					end else if (state_end &&
						state_ff == cpuseq_pkg::st_idle) begin
						gap_cnt_ff <= gap_cnt_ff + 3'h1;
					end
				end
				default: begin
					if (ack && cur_inta2_ff) begin
						interrupt_acknowledge_cycle_ff <= cpuseq_pkg::ia_off;
					end
				end
			endcase
		end
	end

	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rstn_in);

	state_on_edge_a: assert property (
		state_ff != $past(state_ff) |-> $past(phase_ff))
		else $error("bus state changed mid state");
	pipe_first_a: assert property (
		state_ff == cpuseq_pkg::st_pipe_first && state_end && !pending
		|=> state_ff == cpuseq_pkg::st_pipe_no_next)
		else $error("pipe first without request left wrongly");
	read_float_a: assert property (
		in_second && !cur_wr_ff |-> !data_oe_out)
		else $error("data driven during read");
	write_drive_a: assert property (
		state_ff == cpuseq_pkg::st_pipe_first && !state_end && cur_wr_ff
		|=> data_oe_out ##1 data_oe_out)
		else $error("write data not driven");
	wait_repeat_a: assert property (
		state_ff == cpuseq_pkg::st_pipe_next && state_end && ready_n_in
		|=> state_ff == cpuseq_pkg::st_pipe_next)
		else $error("wait state not repeated");
	ready_ignored_a: assert property (
		(state_ff == cpuseq_pkg::st_pipe_first ||
		state_ff == cpuseq_pkg::st_first) && state_end
		|=> in_second && !rd_valid_out && !vector_valid_out)
		else $error("ready taken at end of a first state");
	strobe_held_a: assert property (
		state_ff == cpuseq_pkg::st_pipe_next &&
		$past(state_ff) == cpuseq_pkg::st_pipe_next
		|-> !address_strobe_n_out && $stable(addr_out))
		else $error("pipelined address not held");
	interrupt_acknowledge_cycle_addr_a: assert property (
		state_ff == cpuseq_pkg::st_first && cur_interrupt_acknowledge_cycle_ff && !cur_inta2_ff
		|-> addr_out == cpuseq_pkg::INTA1_ADDR && high_byte_enable_n_out)
		else $error("first acknowledge address wrong");
	gap_locked_a: assert property (
		interrupt_acknowledge_cycle_ff == cpuseq_pkg::ia_gap |-> !bus_lock_n_out)
		else $error("lock dropped between acknowledges");
	idle_quiet_a: assert property (
		state_ff == cpuseq_pkg::st_idle |-> address_strobe_n_out)
		else $error("strobe in idle state");

	pipe_run_c: cover property (
		state_ff == cpuseq_pkg::st_pipe_next ##2
		state_ff == cpuseq_pkg::st_pipe_first);
	no_next_c: cover property (
		state_ff == cpuseq_pkg::st_pipe_no_next ##2
		state_ff == cpuseq_pkg::st_pipe_next);
	vector_c: cover property (vector_valid_out);
	late_na_c: cover property (
		state_ff == cpuseq_pkg::st_second ##2
		state_ff == cpuseq_pkg::st_pipe_next);
endmodule

// >>> rtl/cpuseq_pkg.sv
// Shared constants and types of the processor-side bus sequencer.
// Assumes one clock at double rate; two clock periods make one bus state.
package cpuseq_pkg;

	// Bus widths: address pins carry word address bits 23..1
	localparam int unsigned ADDR_W = 23;
	localparam int unsigned DATA_W = 16;
	localparam int unsigned BE_W = 2;
	localparam int unsigned VEC_W = 8;

	// Timing: input clock period and clocks per bus state
	localparam int unsigned CLK_PERIOD_NS = 100;
	localparam int unsigned CLKS_PER_STATE = 2;
	localparam logic PHASE_ONE = 1'b0;
	localparam logic PHASE_TWO = 1'b1;

	// Packed request word layout in the request buffer
	localparam int unsigned REQ_WDATA_LSB = 0;
	localparam int unsigned REQ_ADDR_LSB = 16;
	localparam int unsigned REQ_BE_LSB = 39;
	localparam int unsigned REQ_WR_BIT = 41;
	localparam int unsigned REQ_DC_BIT = 42;
	localparam int unsigned REQ_MIO_BIT = 43;
	localparam int unsigned REQ_LOCK_BIT = 44;
	localparam int unsigned REQ_W = 45;

	// Interrupt acknowledge cycle addresses and byte enables
	localparam logic [22:0] INTA1_ADDR = 23'h000002;
	localparam logic [22:0] INTA2_ADDR = 23'h000000;
	localparam logic [1:0] INTERRUPT_ACKNOWLEDGE_CYCLE_BE_N = 2'h2;
	localparam logic [2:0] INTERRUPT_ACKNOWLEDGE_CYCLE_GAP_LAST = 3'h3;
	localparam logic [2:0] GAP_CNT_RST = 3'h0;

	// Reset values of the bus pins
	localparam logic [22:0] ADDR_RST = 23'h000000;
	localparam logic [1:0] BE_N_IDLE = 2'h3;
	localparam logic [15:0] DATA_RST = 16'h0000;
	localparam logic [7:0] VEC_RST = 8'h00;

	// Bus states
	typedef enum logic [2:0] {
		st_idle = 3'b000,
		st_first = 3'b001,
		st_second = 3'b010,
		st_pipe_first = 3'b011,
		st_pipe_next = 3'b100,
		st_pipe_no_next = 3'b101
	} cpuseq_bus_state_type;

	// Interrupt acknowledge sequence
	typedef enum logic [2:0] {
		ia_off = 3'b000,
		ia_req1 = 3'b001,
		ia_busy1 = 3'b010,
		ia_gap = 3'b011,
		ia_busy2 = 3'b100
	} cpuseq_interrupt_acknowledge_cycle_state_type;

endpackage

// >>> rtl/cpuseq_buf2.sv
// Two-entry request buffer with valid and ready on both sides.
// Assumes the drain side may hold out_ready low for any time.
`timescale 1ns/1ps
module cpuseq_buf2 #(
	parameter int unsigned WIDTH = cpuseq_pkg::REQ_W
) (
	input wire logic clk_sys_in,
	input wire logic rstn_in,
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);
	logic [WIDTH-1:0] slot_ff [2]; // Slot 0 is the head
	logic v0_ff; // Head holds a word
	logic v1_ff; // Tail holds a word
	logic nxt_v0;
	logic nxt_v1;
	logic push;
	logic pop;

	assign push = in_valid_in & in_ready_out;
	assign pop = out_ready_in & v0_ff;
	assign out_valid_out = v0_ff;
	assign out_data_out = slot_ff[0];

	// Next occupancy
	always_comb begin
		nxt_v0 = v0_ff;
		nxt_v1 = v1_ff;
		if (pop) begin
			nxt_v0 = v1_ff | push;
			nxt_v1 = v1_ff & push;
		end else if (push) begin
			nxt_v0 = 1'b1;
			nxt_v1 = v0_ff;
		end
	end

	// Occupancy and ready; ready is low only when both slots fill
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			v0_ff <= 1'b0;
			v1_ff <= 1'b0;
			in_ready_out <= 1'b1;
		end else begin
			v0_ff <= nxt_v0;
			v1_ff <= nxt_v1;
			in_ready_out <= ~(nxt_v0 & nxt_v1);
		end
	end

	// Storage moves forward on a pop, fills the first free slot on a push
	always_ff @(posedge clk_sys_in) begin
		if (pop) begin
			if (v1_ff) begin
				slot_ff[0] <= slot_ff[1];
			end else begin
				slot_ff[0] <= in_data_in;
			end
			if (v1_ff & push) begin
				slot_ff[1] <= in_data_in;
			end
		end else if (push) begin
			if (v0_ff) begin
				slot_ff[1] <= in_data_in;
			end else begin
				slot_ff[0] <= in_data_in;
			end
		end
	end
endmodule

// >>> verification/cpuseq_far_model.sv
// Far-side model: decodes bus cycles and answers with ready after set waits.
// Assumes the strobe marks each cycle start; ready is seen at phase two.
`timescale 1ns/1ps
module cpuseq_far_model #(
	parameter logic [7:0] VEC = 8'ha7
) (
	input wire logic clk_sys_in,
	input wire logic rstn_in,
	input wire logic [1:0] waits_in,
	input wire logic na_en_in,
	input wire logic strobe_n_in,
	input wire logic [22:0] addr_in,
	input wire logic [1:0] be_n_in,
	input wire logic wr_in,
	input wire logic dc_in,
	input wire logic mio_in,
	input wire logic lock_n_in,
	input wire logic [15:0] data_in,
	input wire logic oe_in,
	output logic ready_n_out,
	output logic [15:0] data_out,
	output logic na_n_out,
	output logic [15:0] wdata_out,
	output logic [7:0] nstart_out,
	output logic [7:0] npipe_out,
	output logic lock_start_out,
	output logic [7:0] gap_out,
	output logic [24:0] log_prev_out,
	output logic [24:0] log_last_out
);
	logic busy_ff, pend_ff, hold_ff, wr_ff, rd_ff, vec_ff, ack;
	logic [3:0] cnt_ff, ack_at;
	logic [22:0] cur_ff;
	logic [7:0] idle_ff;
	logic [28:0] cap_ff, now, src;
	// Cycle definition as seen now, and as last strobed
	assign now = {lock_n_in, mio_in, dc_in, wr_in, be_n_in, addr_in};
	assign src = strobe_n_in ? cap_ff : now;
	// Ready spans one whole bus state, so one phase-two edge sees it;
	// it is also shown at the end of each first state, which must not count
	assign ack_at = 4'(3 + 2 * waits_in);
	assign ack = busy_ff && cnt_ff == ack_at;
	assign ready_n_out = !(busy_ff && (ack || cnt_ff == ack_at - 4'h1 ||
		cnt_ff == 4'h1));
	// Next address asked once per cycle, one level over its opening
	assign na_n_out = !(na_en_in && busy_ff && cnt_ff <= 4'h3);
	// Word or vector only while ready is shown; churning pattern otherwise
	assign data_out = (rd_ff && !ready_n_out) ?
		(vec_ff ? {8'h00, VEC} : {~cur_ff[7:0], cur_ff[7:0]}) :
		({16{cnt_ff[0]}} ^ 16'h5a5a);
	// Cycle tracking, write hold capture and logging
	always_ff @(posedge clk_sys_in or negedge rstn_in) begin
		if (!rstn_in) begin
			{busy_ff, pend_ff, hold_ff, wr_ff, rd_ff, vec_ff} <= 6'h00;
			{cnt_ff, cur_ff, idle_ff, cap_ff} <= '0;
			{wdata_out, nstart_out, npipe_out, gap_out} <= '0;
			{log_prev_out, log_last_out} <= '0;
			lock_start_out <= 1'b1;
		end else begin
			if (!strobe_n_in) cap_ff <= now;
			if (busy_ff && !strobe_n_in) pend_ff <= 1'b1;
			if (!busy_ff && strobe_n_in) idle_ff <= idle_ff + 8'h01;
			hold_ff <= ack && wr_ff;
			// Write data must still stand one clock past acknowledge
			if (hold_ff) wdata_out <= oe_in ? data_in : 16'h0bad;
			if ((!busy_ff && !strobe_n_in) || (ack && (pend_ff || !strobe_n_in))) begin
				busy_ff <= 1'b1;
				cnt_ff <= busy_ff ? 4'h0 : 4'h1;
				pend_ff <= 1'b0;
				cur_ff <= src[22:0];
				wr_ff <= src[25];
				rd_ff <= !src[25];
				vec_ff <= src[22:0] == 23'h0 && src[27:25] == 3'h0;
				lock_start_out <= src[28];
				nstart_out <= nstart_out + 8'h01;
				npipe_out <= npipe_out + {7'h00, busy_ff};
				gap_out <= idle_ff;
				idle_ff <= 8'h00;
				log_prev_out <= log_last_out;
				log_last_out <= src[24:0];
			end else if (ack) begin
				busy_ff <= 1'b0;
				cnt_ff <= 4'h0;
			end else if (busy_ff) begin
				cnt_ff <= cnt_ff + 4'h1;
			end
		end
	end
endmodule

// >>> verification/cpuseq_bus_unit_tb.sv
// Self-checking bench for the bus sequencer against the far-side model.
// Assumes the sequencer body carries its own assertions.
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin err_count++; $display("unexpected at %0t got %h expected %h", $time, (g), (e)); end end
module cpuseq_bus_unit_tb;
	logic clk_sys_in = 1'b0, rstn_in = 1'b0, req_valid = 1'b0;
	logic [22:0] req_addr = '0;
	logic [15:0] req_wdata = '0;
	logic req_write = 1'b0, req_lock = 1'b0, maskable_interrupt_request = 1'b0, maskable_interrupt_request_en = 1'b0;
	logic na_en = 1'b0;
	logic [1:0] waits = 2'h0;
	logic req_ready_out, rd_valid_out, vector_valid_out, address_strobe_n_out;
	logic [15:0] rd_data_out, data_out, data_in, wdata;
	logic [7:0] vector_out, nstart, npipe, gap, n0;
	logic [22:0] addr_out;
	logic high_byte_enable_n_out, low_byte_enable_n_out, write_read_out;
	logic data_control_out, mem_io_out, bus_lock_n_out, data_oe_out;
	logic ready_n, na_n, lock_start;
	logic [24:0] log_prev, log_last;
	int err_count = 0, total_checks = 0;
	// Clock at 10 MHz
	initial forever #50 clk_sys_in = ~clk_sys_in;
	cpuseq_bus_unit u_cpuseq_bus_unit (.clk_sys_in(clk_sys_in),
		.rstn_in(rstn_in), .req_valid_in(req_valid),
		.req_ready_out(req_ready_out), .req_addr_in(req_addr),
		.req_be_n_in(2'h0), .req_write_in(req_write),
		.req_data_ctl_in(1'b1), .req_mem_io_in(1'b1),
		.req_lock_in(req_lock), .req_wdata_in(req_wdata),
		.rd_valid_out(rd_valid_out), .rd_data_out(rd_data_out),
		.maskable_interrupt_request_in(maskable_interrupt_request), .maskable_interrupt_request_enable_in(maskable_interrupt_request_en),
		.vector_valid_out(vector_valid_out), .vector_out(vector_out),
		.address_strobe_n_out(address_strobe_n_out), .addr_out(addr_out),
		.high_byte_enable_n_out(high_byte_enable_n_out),
		.low_byte_enable_n_out(low_byte_enable_n_out),
		.write_read_out(write_read_out), .data_control_out(data_control_out),
		.mem_io_out(mem_io_out), .bus_lock_n_out(bus_lock_n_out),
		.data_in(data_in), .data_out(data_out), .data_oe_out(data_oe_out),
		.ready_n_in(ready_n), .next_address_request_n_in(na_n));
	cpuseq_far_model u_cpuseq_far_model (.clk_sys_in(clk_sys_in),
		.rstn_in(rstn_in), .waits_in(waits), .na_en_in(na_en),
		.strobe_n_in(address_strobe_n_out), .addr_in(addr_out),
		.be_n_in({high_byte_enable_n_out, low_byte_enable_n_out}),
		.wr_in(write_read_out), .dc_in(data_control_out),
		.mio_in(mem_io_out), .lock_n_in(bus_lock_n_out), .data_in(data_out),
		.oe_in(data_oe_out), .ready_n_out(ready_n), .data_out(data_in),
		.na_n_out(na_n), .wdata_out(wdata), .nstart_out(nstart),
		.npipe_out(npipe), .lock_start_out(lock_start), .gap_out(gap),
		.log_prev_out(log_prev), .log_last_out(log_last));
	// Expected read word for an address
	function automatic logic [15:0] word(input logic [22:0] a);
		return {~a[7:0], a[7:0]};
	endfunction
	// Offer one request and hold it until taken; valid stays up
	task automatic send(input logic [22:0] a, input logic wr, lk,
		input logic [15:0] wd);
		req_addr = a;
		req_write = wr;
		req_lock = lk;
		req_wdata = wd;
		req_valid = 1'b1;
		while (req_ready_out !== 1'b1) @(posedge clk_sys_in) #1;
		@(posedge clk_sys_in) #1;
	endtask
	// Wait a bounded time for a read pulse and judge its word
	task automatic get_rd(input logic [15:0] e);
		int n;
		n = 0;
		while (rd_valid_out !== 1'b1 && n < 80) begin
			@(posedge clk_sys_in) #1;
			n++;
		end
		`CHK(rd_valid_out, 1'b1)
		`CHK(rd_data_out, e)
		@(posedge clk_sys_in) #1;
	endtask
	// Let n clocks pass
	task automatic idle(input int n);
		repeat (n) @(posedge clk_sys_in) #1;
	endtask
	// Bus pins after reset
	task automatic t_reset();
		`CHK(address_strobe_n_out, 1'b1)
		`CHK({bus_lock_n_out, data_oe_out, req_ready_out}, 3'h5)
		$display("test reset done");
	endtask
	// Single read with one wait state, then a locked read
	task automatic t_read();
		waits = 2'h1;
		send(23'h000123, 1'b0, 1'b0, 16'h0000);
		req_valid = 1'b0;
		get_rd(word(23'h000123));
		`CHK(lock_start, 1'b1)
		send(23'h000077, 1'b0, 1'b1, 16'h0000);
		req_valid = 1'b0;
		get_rd(word(23'h000077));
		`CHK(lock_start, 1'b0)
		`CHK(bus_lock_n_out, 1'b1)
		$display("test read done");
	endtask
	// Zero-wait writes with next address asked: no pipelining may start
	task automatic t_write();
		waits = 2'h0;
		na_en = 1'b1;
		n0 = npipe;
		send(23'h000040, 1'b1, 1'b0, 16'hbeef);
		send(23'h000041, 1'b1, 1'b0, 16'h1234);
		req_valid = 1'b0;
		idle(30);
		`CHK(wdata, 16'h1234)
		`CHK(npipe, n0)
		`CHK(data_oe_out, 1'b0)
		$display("test write done");
	endtask
	// Burst of waited reads: pipelining entered, kept, then dropped
	task automatic t_pipe();
		waits = 2'h1;
		n0 = npipe;
		fork
			begin
				for (int i = 0; i < 4; i++)
					send(23'h000010 + 23'(i), 1'b0, 1'b0, 16'h0000);
				req_valid = 1'b0;
			end
			for (int j = 0; j < 4; j++) get_rd(word(23'h000010 + 23'(j)));
		join
		`CHK(npipe - n0, 8'h03)
		n0 = nstart;
		idle(20);
		`CHK(nstart, n0)
		`CHK(address_strobe_n_out, 1'b1)
		// Cycle after the dropped pipeline starts plain again
		n0 = npipe;
		send(23'h000020, 1'b0, 1'b0, 16'h0000);
		req_valid = 1'b0;
		get_rd(word(23'h000020));
		`CHK(npipe, n0)
		na_en = 1'b0;
		$display("test pipe done");
	endtask
	// Masked request ignored; enabled one runs two locked acknowledges
	task automatic t_interrupt_acknowledge_cycle();
		int n;
		n0 = nstart;
		maskable_interrupt_request = 1'b1;
		idle(20);
		`CHK(nstart, n0)
		maskable_interrupt_request_en = 1'b1;
		n = 0;
		while (nstart == n0 && n < 40) begin
			idle(1);
			n++;
		end
		`CHK(nstart == n0, 1'b0)
		maskable_interrupt_request = 1'b0;
		n = 0;
		while (vector_valid_out !== 1'b1 && n < 80) begin
			idle(1);
			n++;
		end
		`CHK(vector_valid_out, 1'b1)
		`CHK(vector_out, 8'ha7)
		`CHK(log_prev, {2'h2, 23'h000002})
		`CHK(log_last, {2'h2, 23'h000000})
		`CHK(gap, 8'h08)
		`CHK(lock_start, 1'b0)
		idle(4);
		`CHK(bus_lock_n_out, 1'b1)
		maskable_interrupt_request_en = 1'b0;
		$display("test interrupt_acknowledge_cycle done");
	endtask
	// Print counts and verdict, then end the run
	task automatic stop_test();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	// Watchdog well past the expected run length
	initial begin
		#2000000;
		err_count++;
		stop_test();
	end
	// Main sequence
	initial begin
		repeat (3) @(posedge clk_sys_in);
		#1 rstn_in = 1'b1;
		idle(1);
		t_reset();
		t_read();
		t_write();
		t_pipe();
		t_interrupt_acknowledge_cycle();
		stop_test();
	end
endmodule
